// ### nic_nested_irq_ctrl.sv
// nic_nested_irq_ctrl: register file, arbiter and entry/exit sequencer.
// assumes: irq lines are asynchronous levels; the core returns from a
// handler with a one-cycle pulse on i_exc_ret and the handler's number.
// limitation: a return that lands while an entry or exit is running is
// dropped, so the core must not return during stacking or unstacking.
// apb: one wait state per access; pready is a one-cycle pulse.
// trade-off: read data is registered in the wait cycle, which costs a
// cycle per access but keeps the address decode off the pready path.
//
// Overview of operation
// - priority 0..15 per irq, 0 most urgent
// - requests sensed by level, not edge
// - priority split into group and subpriority
// - priority changes apply to next arbitration
// - tail-chain straight into next pending handler
// - state stacked on entry, unstacked on exit
// - set-enable write one enables, reads enables
// - pending and enabled irq activates by priority
// - disabled irq can pend, never activates
// - clear-enable write one disables, reads enables
// - set-pending write one pends, reads pending
// - repeated or disabled set-pending still pends
// - clear-pending write one unpends, reads pending
// - clear-pending leaves active state alone
// - active word shows active irqs
// - irqs 0-29 in word 0, word 1
// - four-bit priority fields in eight words
// - only bits 7:4 of each priority byte
// - word n div 4, lane n mod 4
// - trigger word pends given irq number
`timescale 1ns/100ps

module nic_nested_irq_ctrl #(
  parameter int N = nic_pkg::NIC_NUM_IRQ,
  parameter int SUB_BITS = nic_pkg::NIC_SUB_BITS,
  parameter int STACK_CYC = nic_pkg::NIC_STACK_CYC,
  parameter int UNSTACK_CYC = nic_pkg::NIC_UNSTACK_CYC
) (
  input wire logic i_clk_sys, // system clock
  input wire logic i_rst_b, // async reset, active low
  input wire logic i_psel, // apb select
  input wire logic i_penable, // apb access phase
  input wire logic i_pwrite, // apb write
  input wire logic [31:0] i_paddr, // apb byte address
  input wire logic [31:0] i_pwdata, // apb write data
  input wire logic [3:0] i_pstrb, // apb byte strobes
  input wire logic [2:0] i_pprot, // apb protection
  output logic [31:0] o_prdata, // apb read data
  output logic o_pready, // apb ready
  output logic o_pslverr, // apb error
  input wire logic [N-1:0] i_irq, // peripheral request levels
  input wire logic i_exc_ret, // handler return pulse
  input wire logic [4:0] i_ret_num, // number of returning handler
  output nic_pkg::nic_core_t o_core // activation to core
);

  // ==========================================================
  // elaboration checks
  if (N < 1 || N > 30) begin : g_bad_n
    $error("irq count must be 1 to 30");
  end
  if (SUB_BITS < 0 || SUB_BITS > 4) begin : g_bad_sub
    $error("subpriority bits must be 0 to 4");
  end
  if (STACK_CYC < 1 || STACK_CYC > 255 || UNSTACK_CYC < 1 || UNSTACK_CYC > 255) begin : g_bad_cyc
    $error("stack counts must be 1 to 255");
  end
  // the trigger field must reach every implemented line number
  if (nic_pkg::NIC_TRIG_W < 5) begin : g_bad_trig
    $error("trigger field too narrow for irq numbers");
  end
  if (nic_pkg::NIC_PRIO_LSB + nic_pkg::NIC_PRIO_W > 8) begin : g_bad_lane
    $error("priority field must fit its byte lane");
  end

  // ==========================================================
  // state
  typedef struct packed {
    // per-irq state and priority
    logic [N-1:0] en;
    logic [N-1:0] pend;
    logic [N-1:0] act;
    logic [N-1:0][3:0] prio;
    // three-flop pin filter and its settled level
    logic [N-1:0] s1;
    logic [N-1:0] s2;
    logic [N-1:0] s3;
    logic [N-1:0] lvl;
    // entry and exit sequencer
    nic_pkg::nic_fsm_t fsm;
    logic [7:0] cnt;
    logic [4:0] cur;
    // apb answer, held in flops so outputs come straight from them
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    // activation to the core
    nic_pkg::nic_core_t core;
  } nic_state_t;

  nic_state_t s_q;
  nic_state_t s_d;

  // ==========================================================
  // helpers
  function automatic logic [4:0] grp(input logic [3:0] p);
    grp = {1'b0, p} >> SUB_BITS;
  endfunction

  function automatic logic [31:0] strb_mask(input logic [3:0] st);
    strb_mask = {{8{st[3]}}, {8{st[2]}}, {8{st[1]}}, {8{st[0]}}};
  endfunction

  function automatic logic addr_hit(input logic [31:0] a);
    if (a == nic_pkg::NIC_A_SET_EN0) begin
      addr_hit = 1'b1;
    end else if (a == nic_pkg::NIC_A_SET_EN1) begin
      addr_hit = 1'b1;
    end else if (a == nic_pkg::NIC_A_CLR_EN0) begin
      addr_hit = 1'b1;
    end else if (a == nic_pkg::NIC_A_CLR_EN1) begin
      addr_hit = 1'b1;
    end else if (a == nic_pkg::NIC_A_SET_PD0) begin
      addr_hit = 1'b1;
    end else if (a == nic_pkg::NIC_A_SET_PD1) begin
      addr_hit = 1'b1;
    end else if (a == nic_pkg::NIC_A_CLR_PD0) begin
      addr_hit = 1'b1;
    end else if (a == nic_pkg::NIC_A_CLR_PD1) begin
      addr_hit = 1'b1;
    end else if (a == nic_pkg::NIC_A_ACT0) begin
      addr_hit = 1'b1;
    end else if (a == nic_pkg::NIC_A_ACT1) begin
      addr_hit = 1'b1;
    end else if (a >= nic_pkg::NIC_A_PRIO0 && a <= nic_pkg::NIC_A_PRIO7 && a[1:0] == 2'h0) begin
      addr_hit = 1'b1;
    end else if (a == nic_pkg::NIC_A_SW_TRIG) begin
      addr_hit = 1'b1;
    end else begin
      addr_hit = 1'b0;
    end
  endfunction

  // priority word that holds irq n
  function automatic logic prio_hit(input logic [31:0] a, input int n);
    prio_hit = (a == nic_pkg::NIC_A_PRIO0 + 32'(4 * (n / 4)));
  endfunction

  // lowest implemented bit of irq n's byte lane
  function automatic int lane_lsb(input int n);
    lane_lsb = 8 * (n % 4) + nic_pkg::NIC_PRIO_LSB;
  endfunction

  // ==========================================================
  // combinational signals
  // apb decode
  logic acc;
  logic wr_go;
  logic priv_ok;
  logic [31:0] wmask;
  logic [31:0] wbits;
  // write pulses, one bit per irq
  logic [N-1:0] set_en;
  logic [N-1:0] clr_en;
  logic [N-1:0] set_pd;
  logic [N-1:0] clr_pd;
  logic [N-1:0] ret_mask;
  logic [N-1:0] act_eff;
  logic [N-1:0] take_mask;
  logic [31:0] rd_word;
  // arbitration
  logic found;
  logic [3:0] best_p;
  logic [4:0] best_n;
  logic [4:0] run_grp;
  logic cand;
  // software trigger number
  logic [8:0] trig_num;

  always_comb begin
    s_d = s_q;

    // ---- request pins: three flops, change taken when stages 2 and 3 agree
    s_d.s1 = i_irq;
    s_d.s2 = s_q.s1;
    s_d.s3 = s_q.s2;
    // a glitch that reaches only one stage never changes the level
    for (int n = 0; n < N; n++) begin
      if (s_q.s2[n] == s_q.s3[n]) begin
        s_d.lvl[n] = s_q.s3[n];
      end else begin
        s_d.lvl[n] = s_q.lvl[n];
      end
    end

    // ---- apb: one wait state, then pready for one cycle
    acc = i_psel & i_penable;
    // only the privileged bit of pprot matters here
    priv_ok = i_pprot[0];
    wr_go = acc & s_q.pready & i_pwrite & priv_ok & addr_hit(i_paddr);
    wmask = strb_mask(i_pstrb);
    wbits = i_pwdata & wmask;
    // pready rises in the second access cycle; the write lands with it
    s_d.pready = acc & ~s_q.pready;
    s_d.pslverr = acc & ~s_q.pready & (~addr_hit(i_paddr) | ~priv_ok);

    // ---- write decode; only word 0 holds implemented bits
    set_en = '0;
    clr_en = '0;
    set_pd = '0;
    clr_pd = '0;
    trig_num = i_pwdata[nic_pkg::NIC_TRIG_W-1:0];
    if (wr_go) begin
      // word 1 and the active words take writes and drop them
      if (i_paddr == nic_pkg::NIC_A_SET_EN0) begin
        set_en = wbits[N-1:0];
      end else if (i_paddr == nic_pkg::NIC_A_CLR_EN0) begin
        clr_en = wbits[N-1:0];
      end else if (i_paddr == nic_pkg::NIC_A_SET_PD0) begin
        set_pd = wbits[N-1:0];
      end else if (i_paddr == nic_pkg::NIC_A_CLR_PD0) begin
        clr_pd = wbits[N-1:0];
      end else if (i_paddr == nic_pkg::NIC_A_SW_TRIG &&
                   wmask[8:0] == 9'h1ff) begin
        // numbers 30..239 are accepted but have no line behind them
        if (32'(trig_num) < N && 32'(trig_num) <= nic_pkg::NIC_TRIG_MAX) begin
          set_pd[trig_num[4:0]] = 1'b1;
        end
      end
    end

    // ---- priority words: lane n mod 4 of word n div 4, bits 7:4 only
    for (int n = 0; n < N; n++) begin
      if (wr_go && prio_hit(i_paddr, n) && i_pstrb[n % 4]) begin
        // the low nibble is not stored, so it reads back as zero
        s_d.prio[n] = i_pwdata[lane_lsb(n) +: 4];
      end
    end

    // ---- read mux, registered in the wait cycle
    rd_word = nic_pkg::NIC_RST_WORD;
    if (i_paddr == nic_pkg::NIC_A_SET_EN0) begin
      rd_word[N-1:0] = s_q.en;
    end else if (i_paddr == nic_pkg::NIC_A_CLR_EN0) begin
      rd_word[N-1:0] = s_q.en;
    end else if (i_paddr == nic_pkg::NIC_A_SET_PD0) begin
      rd_word[N-1:0] = s_q.pend;
    end else if (i_paddr == nic_pkg::NIC_A_CLR_PD0) begin
      rd_word[N-1:0] = s_q.pend;
    end else if (i_paddr == nic_pkg::NIC_A_ACT0) begin
      rd_word[N-1:0] = s_q.act;
    end else begin
      // word 1, trigger and unmapped reads give zero
      for (int n = 0; n < N; n++) begin
        if (prio_hit(i_paddr, n)) begin
          rd_word[lane_lsb(n) +: 4] = s_q.prio[n];
        end
      end
    end
    s_d.prdata = (acc & ~s_q.pready & ~i_pwrite & priv_ok) ? rd_word : nic_pkg::NIC_RST_WORD;

    // ---- handler return only counts while no entry or exit is running
    // a number beyond the implemented lines is dropped
    ret_mask = '0;
    if (i_exc_ret && s_q.fsm == nic_pkg::NIC_S_IDLE && 32'(i_ret_num) < N) begin
      ret_mask[i_ret_num] = 1'b1;
    end
    act_eff = s_q.act & ~ret_mask;

    // ---- arbiter: lowest value wins, strict compare keeps lowest number
    found = 1'b0;
    best_p = 4'hf;
    best_n = 5'h0;
    for (int n = 0; n < N; n++) begin
      // strict less-than: an equal value later in the scan never displaces
      if (s_q.en[n] && s_q.pend[n] && !act_eff[n] &&
          (!found || s_q.prio[n] < best_p)) begin
        found = 1'b1;
        best_p = s_q.prio[n];
        best_n = 5'(n);
      end
    end
    run_grp = 5'h10;
    for (int n = 0; n < N; n++) begin
      if (act_eff[n] && grp(s_q.prio[n]) < run_grp) begin
        run_grp = grp(s_q.prio[n]);
      end
    end
    // preemption looks at the group alone; subpriority only orders waiters
    cand = found && grp(best_p) < run_grp;

    // ---- sequencer
    take_mask = '0;
    s_d.core.tail = 1'b0;
    case (s_q.fsm)
      nic_pkg::NIC_S_IDLE: begin
        // a return frees its irq first, so a chain sees the freed group
        s_d.cnt = 8'h0;
        if (cand) begin
          take_mask[best_n] = 1'b1;
          s_d.cur = best_n;
          if (i_exc_ret) begin
            s_d.fsm = nic_pkg::NIC_S_VECT;
            s_d.core.tail = 1'b1;
          end else begin
            s_d.fsm = nic_pkg::NIC_S_STACK;
          end
        end else if (i_exc_ret) begin
          s_d.fsm = nic_pkg::NIC_S_UNSTACK;
        end
      end
      nic_pkg::NIC_S_STACK: begin
        // a more urgent late arrival waits for the next arbitration
        s_d.cnt = s_q.cnt + 8'h1;
        if (s_q.cnt == 8'(STACK_CYC - 1)) begin
          s_d.fsm = nic_pkg::NIC_S_VECT;
        end
      end
      nic_pkg::NIC_S_VECT: begin
        // one-cycle vector, then back to idle to arbitrate again
        s_d.fsm = nic_pkg::NIC_S_IDLE;
      end
      nic_pkg::NIC_S_UNSTACK: begin
        // nothing to chain: restore state, then idle
        s_d.cnt = s_q.cnt + 8'h1;
        if (s_q.cnt == 8'(UNSTACK_CYC - 1)) begin
          s_d.fsm = nic_pkg::NIC_S_IDLE;
        end
      end
      default: begin
        // all four codes are states, so this arm is never reached: recover to idle
        s_d.fsm = nic_pkg::NIC_S_IDLE;
      end
    endcase

    // ---- state bits; sets applied after clears so a set wins
    // enable: a set in the same cycle as a clear wins
    // active: a taken irq turns active, a returning one stops
    // pending: a level line re-pends only while its irq is not active
    s_d.en = (s_q.en & ~clr_en) | set_en;
    s_d.act = act_eff | take_mask;
    s_d.pend = (s_q.pend & ~clr_pd & ~take_mask)
             | set_pd
             | (s_q.lvl & ~s_d.act);

    // ---- core outputs follow the next state so they line up with fsm
    s_d.core.vect = (s_d.fsm == nic_pkg::NIC_S_VECT);
    s_d.core.stacking = (s_d.fsm == nic_pkg::NIC_S_STACK);
    s_d.core.unstacking = (s_d.fsm == nic_pkg::NIC_S_UNSTACK);
    s_d.core.num = s_d.cur;
  end

  // ==========================================================
  // registers; every reset value is zero, priority and words alike
  // reset clears the pin filter too, so a line high at release
  // takes the full four edges before it can pend
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // ==========================================================
  // outputs straight from flops
  assign o_prdata = s_q.prdata;
  assign o_pready = s_q.pready;
  assign o_pslverr = s_q.pslverr;
  assign o_core = s_q.core;

endmodule

// ### nic_pkg.sv
// nic_pkg: constants and shared types of the nested interrupt controller.
// assumes: 32-bit APB register access, one system clock.
package nic_pkg;

  // ==========================================================
  // sizes and field positions
  localparam int NIC_NUM_IRQ = 30;
  localparam int NIC_PRIO_W = 4;
  localparam int NIC_PRIO_LSB = 4;
  localparam int NIC_TRIG_W = 9;
  localparam int NIC_TRIG_MAX = 239;
  localparam int NIC_SUB_BITS = 0;

  // ==========================================================
  // register byte addresses
  localparam logic [31:0] NIC_A_SET_EN0 = 32'he000e100;
  localparam logic [31:0] NIC_A_SET_EN1 = 32'he000e104;
  localparam logic [31:0] NIC_A_CLR_EN0 = 32'he000e180;
  localparam logic [31:0] NIC_A_CLR_EN1 = 32'he000e184;
  localparam logic [31:0] NIC_A_SET_PD0 = 32'he000e200;
  localparam logic [31:0] NIC_A_SET_PD1 = 32'he000e204;
  localparam logic [31:0] NIC_A_CLR_PD0 = 32'he000e280;
  localparam logic [31:0] NIC_A_CLR_PD1 = 32'he000e284;
  localparam logic [31:0] NIC_A_ACT0 = 32'he000e300;
  localparam logic [31:0] NIC_A_ACT1 = 32'he000e304;
  localparam logic [31:0] NIC_A_PRIO0 = 32'he000e400;
  localparam logic [31:0] NIC_A_PRIO7 = 32'he000e41c;
  localparam logic [31:0] NIC_A_SW_TRIG = 32'he000ef00;

  // ==========================================================
  // reset values and timing counts
  localparam logic [31:0] NIC_RST_WORD = 32'h00000000;
  localparam logic [3:0] NIC_RST_PRIO = 4'h0;
  localparam int NIC_STACK_CYC = 8;
  localparam int NIC_UNSTACK_CYC = 8;

  // ==========================================================
  // types
  typedef enum logic [1:0] {
    NIC_S_IDLE = 2'h0,
    NIC_S_STACK = 2'h1,
    NIC_S_VECT = 2'h3,
    NIC_S_UNSTACK = 2'h2
  } nic_fsm_t;

  typedef struct packed {
    logic vect;
    logic tail;
    logic [4:0] num;
    logic stacking;
    logic unstacking;
  } nic_core_t;

endpackage

// ### nic_core_model.sv
// nic_core_model: core stand-in that runs handlers and returns from them.
// assumes: fed by the controller's o_core, same clock and reset.
`timescale 1ns/100ps
module nic_core_model (
  input wire logic i_clk_sys, // system clock
  input wire logic i_rst_b, // async reset, active low
  input wire nic_pkg::nic_core_t i_core, // activations
  input wire logic [7:0] i_delay, // handler length in cycles
  output logic o_exc_ret, // return pulse
  output logic [4:0] o_ret_num // returning handler
);
  // ======
  // handlers nest, so the newest one returns first
  logic [4:0] stk[$];
  int cnt;
  always @(posedge i_clk_sys or negedge i_rst_b) begin
    o_exc_ret <= 1'b0;
    if (!i_rst_b) begin
      stk.delete();
      o_ret_num <= 5'h0;
    end else if (i_core.vect) begin
      stk.push_back(i_core.num);
      cnt = i_delay;
    end else if (stk.size() > 0 && !i_core.stacking && !i_core.unstacking) begin
      if (cnt > 0) cnt--;
      else begin
        o_exc_ret <= 1'b1;
        o_ret_num <= stk.pop_back();
        cnt = i_delay;
      end
    end
  end
endmodule

// ### nic_nested_irq_ctrl_props.sv
// nic_nested_irq_ctrl_props: port timing checks of the controller.
// assumes: bound to nic_nested_irq_ctrl built with stack counts of 8.
`timescale 1ns/100ps
module nic_nested_irq_ctrl_props (
  input wire logic i_clk_sys, // system clock
  input wire logic i_rst_b, // async reset, active low
  input wire logic i_psel, // apb select
  input wire logic i_penable, // apb access phase
  input wire logic [2:0] i_pprot, // apb protection
  input wire logic [31:0] o_prdata, // read data
  input wire logic o_pready, // ready
  input wire logic o_pslverr, // error
  input wire logic i_exc_ret, // return pulse
  input wire nic_pkg::nic_core_t o_core // activation
);
  default clocking @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_rst_b);
  // ======
  // entry and exit steps
  sequence s_stack;
    o_core.stacking [*8] ##1 o_core.vect && !o_core.stacking && !o_core.tail;
  endsequence
  sequence s_unstack;
    o_core.unstacking [*8] ##1 !o_core.unstacking;
  endsequence
  ready_time_a: assert property (i_psel && !i_penable |=> !o_pready ##1 o_pready)
    else $error("ready not in second access cycle");
  ready_pulse_a: assert property (o_pready |=> !o_pready)
    else $error("ready longer than one cycle");
  data_idle_a: assert property (!o_pready |-> o_prdata == 32'h0)
    else $error("read data outside ready");
  priv_err_a: assert property (o_pready && !i_pprot[0] |-> o_pslverr && o_prdata == 32'h0)
    else $error("unprivileged access not refused");
  stack_entry_a: assert property ($rose(o_core.stacking) |-> s_stack)
    else $error("stacking length or vector wrong");
  vect_pulse_a: assert property (o_core.vect |=> !o_core.vect)
    else $error("vector longer than one cycle");
  tail_cause_a: assert property (o_core.tail |-> o_core.vect && $past(i_exc_ret))
    else $error("tail chain without return");
  unstack_len_a: assert property ($rose(o_core.unstacking) |-> s_unstack)
    else $error("unstacking length wrong");
  unstack_cause_a: assert property ($rose(o_core.unstacking) |-> $past(i_exc_ret))
    else $error("unstacking without return");
endmodule
bind nic_nested_irq_ctrl nic_nested_irq_ctrl_props i_props (.i_clk_sys, .i_rst_b, .i_psel,
  .i_penable, .i_pprot, .o_prdata, .o_pready, .o_pslverr, .i_exc_ret, .o_core);

// ### tb_top.sv
// tb_top: self-checking bench for the nested interrupt controller.
// assumes: package, controller, checker and core model compiled first.
`timescale 1ns/100ps
module tb_top;
  logic clk = 0, rst_b = 0, psel = 0, pen = 0, pwr = 0, prot0 = 1;
  logic [31:0] addr = 0, wdat = 0, r, rdat;
  logic [29:0] irq = 0;
  logic [7:0] dly = 8'd200;
  logic [3:0] strb = 4'hf;
  logic eret, rdy, err;
  logic [4:0] rnum;
  logic [33:0] note;
  nic_pkg::nic_core_t core;
  logic [33:0] aq[$];
  logic [5:0] vq[$];
  logic [15:0] ra[5] = '{16'he100, 16'he104, 16'he200, 16'he300, 16'he400};
  int bad_count = 0, tests_run = 0, seed = 32'h77b4cca2;
  always #10 clk = ~clk;
  nic_nested_irq_ctrl i_nic_nested_irq_ctrl (.i_clk_sys(clk), .i_rst_b(rst_b), .i_psel(psel),
    .i_penable(pen), .i_pwrite(pwr), .i_paddr(addr), .i_pwdata(wdat), .i_pstrb(strb),
    .i_pprot({2'h0, prot0}), .o_prdata(rdat), .o_pready(rdy), .o_pslverr(err), .i_irq(irq),
    .i_exc_ret(eret), .i_ret_num(rnum), .o_core(core));
  nic_core_model i_nic_core_model (.i_clk_sys(clk), .i_rst_b(rst_b), .i_core(core),
    .i_delay(dly), .o_exc_ret(eret), .o_ret_num(rnum));
  // ======
  // compare, verdict and bus tasks
  task automatic chk(input string s, input logic [31:0] e, g);
    tests_run++;
    if (e !== g) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  function automatic logic [31:0] a(input logic [15:0] x);
    return {16'he000, x};
  endfunction
  // note: {check data, expected error, expected data}
  task automatic apb(input logic w, input logic [31:0] ad, d, input logic [33:0] e);
    int n;
    aq.push_back(e);
    pwr <= w;
    addr <= ad;
    wdat <= d;
    psel <= 1;
    @(posedge clk);
    pen <= 1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (rdy !== 1'b1 && n < 50);
    if (n >= 50) begin
      bad_count++;
      stop_test();
    end
    psel <= 0;
    pen <= 0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [15:0] x, input logic [31:0] d);
    apb(1, a(x), d, 34'h0);
  endtask
  task automatic rd(input logic [15:0] x, input logic [31:0] e);
    apb(0, a(x), 32'h0, {2'b10, e});
  endtask
  // the 600-cycle bound covers two 200-cycle handlers plus unstacking in one wait
  task automatic wait_vect();
    int n;
    n = 0;
    while (core.vect !== 1'b1 && n < 600) begin
      @(posedge clk);
      n++;
    end
    if (n >= 600) begin
      bad_count++;
      stop_test();
    end
    @(posedge clk);
  endtask
  // ======
  // result watcher
  always @(posedge clk) begin
    if (rdy === 1'b1) begin
      note = aq.pop_front();
      chk("pslverr", {31'h0, note[32]}, {31'h0, err});
      if (note[33]) chk("prdata", note[31:0], rdat);
    end
    if (core.vect === 1'b1) chk("vector", {26'h0, vq.pop_front()}, {26'h0, core.tail, core.num});
  end
  // ======
  // main sequence
  initial begin
    repeat (5) @(posedge clk);
    rst_b <= 1;
    @(posedge clk);
    foreach (ra[i]) rd(ra[i], 32'h0);
    apb(0, a(16'he008), 32'h0, {2'b11, 32'h0});
    r = $random(seed) & 32'h3fffffff;
    wr(16'he100, r);
    wr(16'he100, 32'h0);
    wr(16'he180, 32'h0);
    rd(16'he180, r);
    wr(16'he104, 32'hffffffff);
    rd(16'he104, 32'h0);
    wr(16'he180, 32'h3fffffff);
    prot0 <= 0;
    apb(1, a(16'he100), 32'h3fffffff, {2'b01, 32'h0});
    prot0 <= 1;
    rd(16'he100, 32'h0);
    for (int i = 0; i < 8; i++) begin
      r = $random(seed);
      wr(16'he400 + 16'(4 * i), r);
      rd(16'he400 + 16'(4 * i), r & (i == 7 ? 32'h0000f0f0 : 32'hf0f0f0f0));
    end
    wr(16'he41c, 32'h0);
    strb <= 4'h2;
    wr(16'he41c, 32'hffffffff);
    strb <= 4'hf;
    rd(16'he41c, 32'h0000f000);
    wr(16'hef00, 32'h3);
    wr(16'hef00, 32'd100);
    wr(16'he200, 32'h10);
    wr(16'he200, 32'h10);
    rd(16'he280, 32'h18);
    wr(16'he280, 32'h8);
    rd(16'he200, 32'h10);
    wr(16'he280, 32'h3fffffff);
    wr(16'he404, 32'h10002000);
    wr(16'he408, 32'h00001000);
    vq = '{6'h07, 6'h05, 6'h29};
    wr(16'he100, 32'h2a0);
    wr(16'he200, 32'h2a0);
    wait_vect();
    rd(16'he300, 32'h80);
    wr(16'he280, 32'h80);
    rd(16'he300, 32'h80);
    rd(16'he200, 32'h220);
    wr(16'he404, 32'h10000000);
    wait_vect();
    wait_vect();
    repeat (260) @(posedge clk);
    dly <= 8'd30;
    vq.push_back(6'h0c);
    wr(16'he100, 32'h1000);
    irq[12] <= 1'b1;
    wait_vect();
    irq[12] <= 1'b0;
    wr(16'he280, 32'h1000);
    repeat (60) @(posedge clk);
    rd(16'he200, 32'h0);
    rd(16'he300, 32'h0);
    chk("vectors left", 32'h0, vq.size());
    stop_test();
  end
endmodule
